//--- pssb_pkg.sv
// Shared constants and types for the pipelined synchronous SRAM bus block.
package pssb_pkg;
    localparam int unsigned ADDR_W = 18;
    localparam int unsigned DEPTH = 262144;
    localparam int unsigned LANES = 4;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned LANE_W = 9;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned WORD_W = 36;
    localparam int unsigned BURST_W = 2;
    localparam logic [1:0] SLEEP_CYCLES = 2'h2;
    localparam logic [1:0] SLEEP_CNT_RST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
    localparam logic [WORD_W-1:0] WORD_RST = 36'h000000000;
    localparam logic [LANES-1:0] BW_NONE_N = 4'hf;

    typedef enum logic [1:0] {
        PSSB_IDLE,
        PSSB_READ,
        PSSB_WRITE
    } pssb_op_e;

    typedef enum logic [1:0] {
        PSSB_AWAKE,
        PSSB_ENTERING,
        PSSB_ASLEEP,
        PSSB_WAKING
    } pssb_sleep_e;

    typedef struct packed {
        pssb_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] bw_n;
    } pssb_stage_s;

    localparam pssb_stage_s STAGE_RST = '{op: PSSB_IDLE, addr: ADDR_RST, bw_n: BW_NONE_N};
endpackage : pssb_pkg

//--- pssb_mem_if.sv
// Carrier between the access control and the word storage.
interface pssb_mem_if;
    import pssb_pkg::*;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [LANES-1:0] wr_lane;
    logic [WORD_W-1:0] wr_data;
    logic [ADDR_W-1:0] rd_addr;
    logic [WORD_W-1:0] rd_data;

    modport ctrl (
        output wr_en,
        output wr_addr,
        output wr_lane,
        output wr_data,
        output rd_addr,
        input rd_data
    );

    modport store (
        input wr_en,
        input wr_addr,
        input wr_lane,
        input wr_data,
        input rd_addr,
        output rd_data
    );
endinterface : pssb_mem_if

//--- pssb_store.sv
// Word storage built as four independently written byte lanes.
module pssb_store (
    input wire logic mclk, // Core clock.
    pssb_mem_if.store mem // Storage port.
);
    import pssb_pkg::*;

    // ------------------------------------------------------------
    // Byte lanes
    // ------------------------------------------------------------
    for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
        logic [LANE_W-1:0] lane_mem [0:DEPTH-1];

        always_ff @(posedge mclk) begin
            if (mem.wr_en && mem.wr_lane[lane]) begin
                lane_mem[mem.wr_addr] <= mem.wr_data[lane*LANE_W +: LANE_W];
            end
        end

        assign mem.rd_data[lane*LANE_W +: LANE_W] = lane_mem[mem.rd_addr];
    end
endmodule // pssb_store

//--- pssb_top.sv
// Pipelined synchronous burst SRAM access logic with zero bus turnaround.
//
// Contract
// - Unselected load edge deselects, bus undriven; advance edges keep deselecting.
// - Selected load with write enable high starts read burst at pin address.
// - Advance during read burst ignores selects, reads next burst address.
// - Read start with output enable off loads address, bus stays tristated.
// - Read advance with output enable off steps address, bus stays tristated.
// - Selected load with write enable low and a byte select starts write.
// - Advance during write burst writes next address using that beat's byte selects.
// - Write start with no byte selected alters nothing, bus tristated.
// - Write advance with no byte selected steps address, writes nothing.
// - Clock hold high freezes every register except the sleep state and count, as if the edge never came.
// - Any write cycle releases all data and parity lines.
// - Output enable is asynchronous and masked during write cycles.
// - Read drives lines only with output enable active and device selected.
// - After reset the device is deselected with all lines tristated.
// - Each byte lane with parity is written only when its select is low.
// - Only the operation in progress, output enable and sleep steer the drivers.
// - Write data is latched two edges after the address, drivers off between.
// - Burst counter steps two low address bits, interleaved or linear by strap.
// - Sleep tristates the bus; entry and exit take two cycles each.
module pssb_top (
    input wire logic mclk, // Core clock, rising edge.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic [pssb_pkg::ADDR_W-1:0] address, // Word address.
    input wire logic chip_select_1_n, // Chip select, active low.
    input wire logic chip_select_2, // Chip select, active high.
    input wire logic chip_select_3_n, // Chip select, active low.
    input wire logic advance_or_load, // High advances burst, low loads address.
    input wire logic write_enable_n, // Write enable, active low.
    input wire logic [pssb_pkg::LANES-1:0] byte_write_select_n, // Byte lane selects.
    input wire logic output_enable_n, // Asynchronous output enable, active low.
    input wire logic clock_hold_n, // High makes the device ignore the edge.
    input wire logic sleep_request, // High requests low-power sleep.
    input wire logic burst_order, // High interleaved, low linear.
    input wire logic [pssb_pkg::DATA_W-1:0] data_in, // Data pins, input side.
    output logic [pssb_pkg::DATA_W-1:0] data_out, // Data pins, output side.
    output logic [pssb_pkg::DATA_W-1:0] data_oe, // Data pin drive enables.
    input wire logic [pssb_pkg::LANES-1:0] parity_io_in, // Parity pins, input side.
    output logic [pssb_pkg::LANES-1:0] parity_io_out, // Parity pins, output side.
    output logic [pssb_pkg::LANES-1:0] parity_io_oe, // Parity pin drive enables.
    output logic sleep_active // High while the device sleeps or recovers.
);
    import pssb_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Interleaved order flips the start bits; linear order adds.
    function automatic logic [BURST_W-1:0] burst_step(
        input logic [BURST_W-1:0] start,
        input logic [BURST_W-1:0] count,
        input logic interleave
    );
        logic [BURST_W-1:0] res;
        res = interleave ? (start ^ count) : BURST_W'(start + count);
        return res;
    endfunction

    // Each parity bit sits just above its data byte.
    function automatic logic [WORD_W-1:0] pins_to_word(
        input logic [DATA_W-1:0] d,
        input logic [LANES-1:0] p
    );
        logic [WORD_W-1:0] w;
        w = WORD_RST;
        for (int i = 0; i < LANES; i++) begin
            w[i*LANE_W +: LANE_W] = {p[i], d[i*BYTE_W +: BYTE_W]};
        end
        return w;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pssb_mem_if mem ();

    pssb_op_e burst_op_reg;
    pssb_op_e burst_op_next;
    logic [ADDR_W-1:0] burst_base_reg;
    logic [BURST_W-1:0] burst_cnt_reg;
    logic [BURST_W-1:0] burst_cnt_next;

    pssb_stage_s stage1_reg;
    pssb_stage_s stage2_reg;
    pssb_stage_s issue_next;

    logic [WORD_W-1:0] out_word_reg;
    logic out_drive_reg;

    pssb_sleep_e sleep_state_reg;
    logic [1:0] sleep_cnt_reg;

    logic hold;
    logic selected;
    logic awake;
    logic bus_allowed;
    logic [WORD_W-1:0] bus_word;
    logic [WORD_W-1:0] read_word;
    logic [LANES-1:0] fwd_lane;
    logic [LANES-1:0] lane_oe;

    assign hold = clock_hold_n;

    // Any inactive select deselects.
    assign selected = !chip_select_1_n && chip_select_2 && !chip_select_3_n;

    // A sleep request refuses commands at once.
    assign awake = (sleep_state_reg == PSSB_AWAKE) && !sleep_request;
    assign bus_word = pins_to_word(data_in, parity_io_in);

    // Recovery counts as sleep, so the bus stays released.
    assign sleep_active = sleep_state_reg != PSSB_AWAKE;

    // ------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------
    // The issued beat is decided from the pins on load edges and from the
    // burst state on advance edges, so selects and write enable are only
    // looked at when the address is loaded.
    always_comb begin
        issue_next = STAGE_RST;
        issue_next.bw_n = byte_write_select_n;
        issue_next.addr = address;
        burst_op_next = burst_op_reg;
        burst_cnt_next = BURST_CNT_RST;
        // Sleep cancels any open burst.
        if (!awake) begin
            burst_op_next = PSSB_IDLE;
        end else if (!advance_or_load) begin
            if (!selected) begin
                issue_next.op = PSSB_IDLE;
            end else if (write_enable_n) begin
                issue_next.op = PSSB_READ;
            end else begin
                issue_next.op = PSSB_WRITE;
            end
            // A load opens a burst of its own kind.
            burst_op_next = issue_next.op;
        end else begin
            issue_next.op = burst_op_reg;
            burst_cnt_next = BURST_W'(burst_cnt_reg + BURST_STEP);
            issue_next.addr = {burst_base_reg[ADDR_W-1:BURST_W],
                               burst_step(burst_base_reg[BURST_W-1:0], burst_cnt_next, burst_order)};
        end
    end

    // ------------------------------------------------------------
    // Burst tracking
    // ------------------------------------------------------------
    // Held edges keep the open burst as it is.
    // burst continuation.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            burst_op_reg <= PSSB_IDLE;
        end else if (!hold) begin
            burst_op_reg <= burst_op_next;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            burst_base_reg <= ADDR_RST;
        end else if (!hold && awake && !advance_or_load) begin
            burst_base_reg <= address;
        end
    end

    // A fourth advance wraps to the start address.
    // four-beat counter.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            burst_cnt_reg <= BURST_CNT_RST;
        end else if (!hold) begin
            burst_cnt_reg <= burst_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Pipeline
    // ------------------------------------------------------------
    // Byte selects are captured on every beat, so a burst may change the
    // lanes it writes from one beat to the next.
    // per-beat byte selects.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_reg <= STAGE_RST;
        end else if (!hold) begin
            stage1_reg <= issue_next;
        end
    end

    // The second stage is the write data slot.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stage2_reg <= STAGE_RST;
        end else if (!hold) begin
            stage2_reg <= stage1_reg;
        end
    end

    // ------------------------------------------------------------
    // Storage access
    // ------------------------------------------------------------
    // write data latched at second edge.
    assign mem.wr_en = !hold && (stage2_reg.op == PSSB_WRITE);
    assign mem.wr_addr = stage2_reg.addr;
    assign mem.wr_lane = ~stage2_reg.bw_n;
    // Write data is taken off the pins at the committing edge.
    assign mem.wr_data = bus_word;

    // Reads look up the first stage, one edge early.
    assign mem.rd_addr = stage1_reg.addr;

    // A read fetched at the same edge that an earlier write commits to the
    // same word would see stale lanes, so the bus bytes are forwarded.
    always_comb begin
        read_word = mem.rd_data;
        for (int i = 0; i < LANES; i++) begin
            fwd_lane[i] = mem.wr_en && mem.wr_lane[i] && (stage2_reg.addr == stage1_reg.addr);
            if (fwd_lane[i]) begin
                read_word[i*LANE_W +: LANE_W] = bus_word[i*LANE_W +: LANE_W];
            end
        end
    end

    pssb_store u_store (
        .mclk(mclk),
        .mem(mem)
    );

    // ------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------
    // Dummy reads load the register too; only the enables differ.
    // read data slot.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            out_word_reg <= WORD_RST;
        end else if (!hold && stage1_reg.op == PSSB_READ) begin
            out_word_reg <= read_word;
        end
    end

    // The drivers are switched off at the edge between a write address and
    // its data, which is what lets reads and writes follow back to back.
    // write releases lines.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            out_drive_reg <= 1'b0;
        end else if (!hold) begin
            out_drive_reg <= stage1_reg.op == PSSB_READ;
        end
    end

    // ------------------------------------------------------------
    // Sleep control
    // ------------------------------------------------------------
    // Pending accesses are not protected across sleep entry; the controller
    // is expected to have deselected the device before raising the request.
    // two-cycle entry and exit.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sleep_state_reg <= PSSB_AWAKE;
        end else begin
            unique case (sleep_state_reg)
                PSSB_AWAKE: begin
                    if (sleep_request) begin
                        sleep_state_reg <= PSSB_ENTERING;
                    end
                end
                PSSB_ENTERING: begin
                    if (!sleep_request) begin
                        sleep_state_reg <= PSSB_WAKING;
                    end else if (sleep_cnt_reg == SLEEP_CYCLES - 2'h1) begin
                        sleep_state_reg <= PSSB_ASLEEP;
                    end
                end
                PSSB_ASLEEP: begin
                    if (!sleep_request) begin
                        sleep_state_reg <= PSSB_WAKING;
                    end
                end
                PSSB_WAKING: begin
                    if (sleep_request) begin
                        sleep_state_reg <= PSSB_ENTERING;
                    end else if (sleep_cnt_reg == SLEEP_CYCLES - 2'h1) begin
                        sleep_state_reg <= PSSB_AWAKE;
                    end
                end
            endcase
        end
    end

    // The count restarts when the request turns around.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sleep_cnt_reg <= SLEEP_CNT_RST;
        end else if ((sleep_state_reg == PSSB_AWAKE) || (sleep_state_reg == PSSB_ASLEEP)) begin
            sleep_cnt_reg <= SLEEP_CNT_RST;
        end else if ((sleep_state_reg == PSSB_ENTERING) != sleep_request) begin
            sleep_cnt_reg <= SLEEP_CNT_RST;
        end else begin
            sleep_cnt_reg <= sleep_cnt_reg + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Output enable is not sampled: it gates the registered drive decision
    // directly, so turning it off releases the bus within the same cycle.
    // asynchronous, masked output enable.
    // drivers steered by cycle and output enable.
    assign bus_allowed = out_drive_reg && !output_enable_n && !sleep_request && !sleep_active;

    // All lanes share one enable, so the bus turns around as a whole.
    for (genvar lane = 0; lane < LANES; lane++) begin : g_pins
        assign lane_oe[lane] = bus_allowed;
        // lane is eight data bits and one parity bit.
        assign data_out[lane*BYTE_W +: BYTE_W] = out_word_reg[lane*LANE_W +: BYTE_W];
        assign parity_io_out[lane] = out_word_reg[lane*LANE_W + BYTE_W];
        assign data_oe[lane*BYTE_W +: BYTE_W] = {BYTE_W{lane_oe[lane]}};
        assign parity_io_oe[lane] = lane_oe[lane];
    end
endmodule // pssb_top

//--- pssb_checker_assertions.sv
// Concurrent checks on the pins of the pipelined synchronous SRAM bus block.
module pssb_checker (
    input wire logic mclk, // Core clock.
    input wire logic reset_n, // Reset, active low.
    input wire logic chip_select_1_n, // Select, active low.
    input wire logic chip_select_2, // Select, active high.
    input wire logic chip_select_3_n, // Select, active low.
    input wire logic advance_or_load, // Advance or load.
    input wire logic write_enable_n, // Write enable, active low.
    input wire logic output_enable_n, // Output enable, active low.
    input wire logic clock_hold_n, // High ignores the edge.
    input wire logic sleep_request, // Sleep request.
    input wire logic [pssb_pkg::DATA_W-1:0] data_out, // Data out.
    input wire logic [pssb_pkg::DATA_W-1:0] data_oe, // Data enables.
    input wire logic [pssb_pkg::LANES-1:0] parity_io_out, // Parity out.
    input wire logic [pssb_pkg::LANES-1:0] parity_io_oe, // Parity enables.
    input wire logic sleep_active // Sleep state.
);
    timeunit 1ns;
    timeprecision 100ps;
    import pssb_pkg::*;
    logic load;
    logic sel;
    logic quiet;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // A load edge is only taken when awake and not stalled.
    assign load = !clock_hold_n && !sleep_request && !sleep_active && !advance_or_load;
    assign sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
    assign quiet = data_oe == '0 && parity_io_oe == '0;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_reset_idle;
        $rose(reset_n) |-> quiet;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("drivers on after reset");
    property p_oe_off;
        output_enable_n |-> quiet;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("drivers on with output enable off");
    property p_sleep_off;
        sleep_request || sleep_active |-> quiet;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("drivers on while sleeping");
    property p_lanes_same;
        data_oe == {DATA_W{data_oe[0]}} && parity_io_oe == {LANES{data_oe[0]}};
    endproperty
    a_lanes_same: assert property (p_lanes_same) else $error("drive enables differ");
    property p_write_release;
        load && sel && !write_enable_n ##1 !clock_hold_n |-> ##1 quiet;
    endproperty
    a_write_release: assert property (p_write_release) else $error("drivers on in write slot");
    property p_read_drive;
        load && sel && write_enable_n ##1 (!clock_hold_n && !sleep_request) |->
            ##1 (sleep_request || sleep_active || data_oe[0] == !output_enable_n);
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read slot not driven");
    property p_deselect;
        load && !sel ##1 !clock_hold_n |-> ##1 quiet;
    endproperty
    a_deselect: assert property (p_deselect) else $error("drivers on after deselect");
    property p_hold_freeze;
        clock_hold_n |=> $stable(data_out) && $stable(parity_io_out);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze) else $error("output moved on held edge");
    property p_write_keep;
        load && sel && !write_enable_n ##1 !clock_hold_n |-> ##1 $stable(data_out);
    endproperty
    a_write_keep: assert property (p_write_keep) else $error("output moved after write");
    property p_sleep_enter;
        sleep_request && !sleep_active |=> sleep_active;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");
    property p_sleep_exit;
        !sleep_request && sleep_active |-> ##[0:5] !sleep_active;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep not left");
endmodule // pssb_checker

//--- pssb_ctrl_model.sv
// Memory controller model that supplies write data in the write slot.
module pssb_ctrl_model (
    input wire logic mclk, // Core clock.
    input wire logic clock_hold_n, // High stalls the edge.
    input wire logic wr_issue, // A write beat is on the pins.
    input wire logic [pssb_pkg::DATA_W-1:0] wr_data, // Word for that beat.
    input wire logic [pssb_pkg::LANES-1:0] wr_par, // Parity for that beat.
    output logic [pssb_pkg::DATA_W-1:0] ctrl_data = '0, // Data the controller drives.
    output logic [pssb_pkg::LANES-1:0] ctrl_par = '0 // Parity the controller drives.
);
    timeunit 1ns;
    timeprecision 100ps;
    import pssb_pkg::*;
    logic pend_reg = 1'b0;
    logic [WORD_W-1:0] word_reg = '0;
    // write slot
    // Outside the slot the lines toggle so stale data can never pass for a write.
    always @(posedge mclk) begin
        if (!clock_hold_n) begin
            pend_reg <= wr_issue;
            word_reg <= {wr_par, wr_data};
            if (pend_reg) begin
                {ctrl_par, ctrl_data} <= word_reg;
            end else begin
                {ctrl_par, ctrl_data} <= ~{ctrl_par, ctrl_data};
            end
        end
    end
endmodule // pssb_ctrl_model

//--- pssb_bench.sv
// Self-checking bench for the pipelined synchronous SRAM bus block.
module pssb_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import pssb_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] address = '0;
    logic chip_select_1_n = 1'b1;
    logic chip_select_2 = 1'b0;
    logic chip_select_3_n = 1'b1;
    logic advance_or_load = 1'b0;
    logic write_enable_n = 1'b1;
    logic [LANES-1:0] byte_write_select_n = '1;
    logic output_enable_n = 1'b0;
    logic clock_hold_n = 1'b0;
    logic sleep_request = 1'b0;
    logic burst_order = 1'b1;
    logic wr_issue = 1'b0;
    logic [DATA_W-1:0] wr_data = '0;
    logic [LANES-1:0] wr_par = '0;
    logic [DATA_W-1:0] data_in, data_out, data_oe, ctrl_data;
    logic [LANES-1:0] parity_io_in, parity_io_out, parity_io_oe, ctrl_par;
    logic sleep_active;
    int mismatches = 0;
    int num_checks = 0;
    logic [WORD_W-1:0] mem [int];
    logic [1:0] k1 = '0, k2 = '0, bop = '0, cnt = '0, c_op = '0;
    logic [ADDR_W-1:0] a1, a2, base, c_a;
    logic [LANES-1:0] b1, b2, c_bw;
    logic [WORD_W-1:0] w1, w2, c_w, dexp;
    logic dv = 1'b0;
    logic c_hold = 1'b0;
    logic [ADDR_W-1:0] blk [4];
    always #12.5 mclk = ~mclk;
    // The pins carry whichever party has its drivers on.
    assign data_in = (data_oe & data_out) | (~data_oe & ctrl_data);
    assign parity_io_in = (parity_io_oe & parity_io_out) | (~parity_io_oe & ctrl_par);
    pssb_top dut (.mclk, .reset_n, .address, .chip_select_1_n, .chip_select_2, .chip_select_3_n,
        .advance_or_load, .write_enable_n, .byte_write_select_n, .output_enable_n, .clock_hold_n,
        .sleep_request, .burst_order, .data_in, .data_out, .data_oe, .parity_io_in, .parity_io_out,
        .parity_io_oe, .sleep_active);
    pssb_ctrl_model partner (.mclk, .clock_hold_n, .wr_issue, .wr_data, .wr_par, .ctrl_data, .ctrl_par);
    // ----------------------------------------
    // Expectation helpers
    // ----------------------------------------
    // burst address step
    function automatic logic [ADDR_W-1:0] baddr(input logic [ADDR_W-1:0] b, input logic [1:0] n,
                                                input logic il);
        return {b[ADDR_W-1:2], il ? b[1:0] ^ n : b[1:0] + n};
    endfunction
    function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old,
                                                input logic [WORD_W-1:0] nw, input logic [LANES-1:0] bw);
        logic [WORD_W-1:0] r;
        r = old;
        for (int i = 0; i < LANES; i++) begin
            if (!bw[i]) begin
                r[8*i+:8] = nw[8*i+:8];
                r[DATA_W+i] = nw[DATA_W+i];
            end
        end
        return r;
    endfunction
    task automatic chk(input string n, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One edge: retire the sampled command in the model, then drive the next (0 desel, 1 rd, 2 wr, 3 adv).
    task automatic step(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] bw,
                        input logic oe_n, input logic hold);
        logic [2:0] m;
        @(posedge mclk);
        if (!c_hold) begin
            if (k2 == 2'd2) begin
                mem[a2] = merge(mem.exists(a2) ? mem[a2] : '0, w2, b2);
            end
            dv = (k1 == 2'd1);
            if (dv) begin
                dexp = mem[a1];
            end
            {k2, a2, b2, w2} = {k1, a1, b1, w1};
            if (c_op == 2'd3 && bop != 2'd0) begin
                cnt = cnt + 2'd1;
            end else begin
                bop = (c_op == 2'd3) ? 2'd0 : c_op;
                base = c_a;
                cnt = 2'd0;
            end
            {k1, a1, b1, w1} = {bop, baddr(base, cnt, burst_order), c_bw, c_w};
        end
        // Advance edges get random selects, since the device must ignore them there.
        m = (op == 2'd0) ? 3'($urandom_range(7, 1)) : ((op == 2'd3) ? 3'($urandom_range(7, 0)) : 3'd0);
        c_w = {4'($urandom), $urandom};
        {chip_select_3_n, chip_select_2, chip_select_1_n} <= {m[2], ~m[1], m[0]};
        address <= a;
        advance_or_load <= (op == 2'd3);
        write_enable_n <= (op == 2'd3) ? 1'($urandom) : (op != 2'd2);
        byte_write_select_n <= bw;
        output_enable_n <= oe_n;
        clock_hold_n <= hold;
        wr_issue <= (op == 2'd2) || (op == 2'd3 && bop == 2'd2);
        {wr_par, wr_data} <= c_w;
        {c_op, c_a, c_bw, c_hold} = {op, a, bw, hold};
        @(negedge mclk);
        chk("drive_enables", {WORD_W{dv & ~oe_n}}, {parity_io_oe, data_oe});
        if (dv) begin
            chk("read_word", dexp, {parity_io_out, data_out});
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(27223));
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        step(2'd0, '0, '1, 1'b0, 1'b0);
        for (int o = 0; o < 2; o++) begin
            for (int b = 0; b < 4; b++) begin
                blk[b] = ADDR_W'($urandom);
                step(2'd2, blk[b], '0, 1'b1, 1'b0);
                repeat (3) step(2'd3, blk[b], '0, 1'b1, 1'b0);
            end
            // Mix of loads, advances, aborts, stalls and output enable toggles.
            repeat (500) step(2'($urandom), {blk[$urandom_range(3, 0)][ADDR_W-1:2], 2'($urandom)},
                ($urandom_range(3, 0) == 0) ? 4'hf : 4'($urandom), ($urandom_range(3, 0) == 0),
                ($urandom_range(7, 0) == 0));
            repeat (3) step(2'd0, '0, '1, 1'b0, 1'b0);
            @(posedge mclk);
            sleep_request <= 1'b1;
            step(2'd0, '0, '1, 1'b0, 1'b0);
            chk("sleep_entered", 1'b1, sleep_active);
            repeat (3) step(2'd0, '0, '1, 1'b0, 1'b0);
            @(posedge mclk);
            sleep_request <= 1'b0;
            step(2'd0, '0, '1, 1'b0, 1'b0);
            chk("sleep_recovering", 1'b1, sleep_active);
            repeat (3) step(2'd0, '0, '1, 1'b0, 1'b0);
            chk("sleep_left", 1'b0, sleep_active);
            @(posedge mclk);
            burst_order <= 1'b0;
            step(2'd0, '0, '1, 1'b0, 1'b0);
        end
        give_verdict();
    end
    initial begin
        #(25 * 20000);
        mismatches++;
        give_verdict();
    end
endmodule // pssb_bench
bind pssb_top pssb_checker chk (.mclk, .reset_n, .chip_select_1_n, .chip_select_2, .chip_select_3_n,
    .advance_or_load, .write_enable_n, .output_enable_n, .clock_hold_n, .sleep_request, .data_out,
    .data_oe, .parity_io_out, .parity_io_oe, .sleep_active);
